// [hdl/sfp_pkg.sv]
// Shared constants and carriers for the forwarding policy register bank.
// Assumes a 40 MHz core clock and a 32-bit classic Wishbone register bus.
package sfp_pkg;
   localparam int unsigned NPORT      = 4;
   localparam int unsigned PORT_W     = 2;
   localparam int unsigned MAC_W      = 48;
   localparam int unsigned ADDR_W     = 10;
   localparam int unsigned DATA_W     = 32;
   localparam int unsigned CLK_KHZ    = 40000;

   // Register indices; the byte address is four times the index
   localparam logic [7:0] IDX_SELF_IPMC = 8'h86;
   localparam logic [7:0] IDX_RATE_TAG  = 8'h88;
   localparam logic [7:0] IDX_REVISION  = 8'h89;

   // Self filter / unknown IP multicast register
   localparam int unsigned SELF_FILT_BIT = 6;
   localparam int unsigned IPMC_EN_BIT   = 5;
   localparam int unsigned IPMC_MAP_MSB  = 4;
   localparam int unsigned IPMC_MAP_LSB  = 1;
   localparam logic [7:0]  SELF_IPMC_RST = 8'h00;
   localparam logic [7:0]  SELF_IPMC_WM  = 8'h7F;

   // Rate limit / tag policy register
   localparam int unsigned RL_PER_LSB    = 4;
   localparam int unsigned EGR_QUEUE_BIT = 3;
   localparam int unsigned SRC_TAG_BIT   = 2;
   localparam logic [7:0]  RATE_TAG_RST  = 8'h10;
   localparam logic [7:0]  RATE_TAG_WM   = 8'h3C;

   // Revision register layout
   localparam int unsigned REV_LSB       = 4;

   // Ingress measurement windows, in milliseconds
   localparam int unsigned PER_SHORT_MS  = 16;
   localparam int unsigned PER_MID_MS    = 64;
   localparam int unsigned PER_LONG_MS   = 256;

   typedef enum logic [1:0] {
      SFP_PER_SHORT = 2'b00,
      SFP_PER_MID   = 2'b01,
      SFP_PER_LONG  = 2'b10
   } sfp_period_t;

   typedef struct packed {
      logic              valid;
      logic [PORT_W-1:0] egressPort;
      logic [PORT_W-1:0] srcPort;
      logic [MAC_W-1:0]  dstMac;
      logic              unknownIpMc;
   } sfp_req_t;

   typedef struct packed {
      logic             valid;
      logic             selfDrop;
      logic [NPORT-1:0] ipmcMask;
      logic             insertTag;
   } sfp_res_t;
endpackage

// [hdl/sfp_policy_regs.sv]
// Forwarding policy register bank with its per-frame decision logic.
// Assumes decision requests come from logic on clk; the self MAC and the
// per-port tag options come from registers held elsewhere in the switch.

// Behaviour
// - Filter bit set drops frames to own address
// - Filtering at egress against separate self MAC
// - Enable gates unknown IP multicast port map
// - Port map decodes to ports 1..4 bitmap
// - Map bit zero ignored by decode
// - Period field picks 16/64/256 ms window
// - Mode bit picks port or queue limits
// - Select bit uses per-source tag options
// - Otherwise per-port insert bit decides tagging
// - Upper nibble read-only revision, lower reserved
module sfp_policy_regs #(
   parameter int unsigned PER_SHORT_CYC = sfp_pkg::PER_SHORT_MS * sfp_pkg::CLK_KHZ,
   parameter int unsigned PER_MID_CYC   = sfp_pkg::PER_MID_MS * sfp_pkg::CLK_KHZ,
   parameter int unsigned PER_LONG_CYC  = sfp_pkg::PER_LONG_MS * sfp_pkg::CLK_KHZ,
   parameter int unsigned CNT_W         = 24,
   // Arbitrary neutral revision value
   parameter logic [3:0]  REV_CODE      = 4'hA
) (
   // Clock and reset
   input  wire logic                        clk,
   input  wire logic                        rstn,
   // Wishbone slave
   input  wire logic                        wbCyc,
   input  wire logic                        wbStb,
   input  wire logic                        wbWe,
   input  wire logic [sfp_pkg::ADDR_W-1:0]  wbAdr,
   input  wire logic [3:0]                  wbSel,
   input  wire logic [sfp_pkg::DATA_W-1:0]  wbDatW,
   output logic      [sfp_pkg::DATA_W-1:0]  wbDatR,
   output logic                             wbAck,
   // Switch context
   input  wire logic [sfp_pkg::MAC_W-1:0]   selfMac,
   input  wire logic [sfp_pkg::NPORT-1:0]   portInsertTag,
   input  wire logic [sfp_pkg::NPORT*sfp_pkg::NPORT-1:0] srcTagMask,
   // Decision request and result
   input  wire sfp_pkg::sfp_req_t           req,
   output sfp_pkg::sfp_res_t                res,
   // Rate limit steering
   output logic                             ingressTick,
   output logic [1:0]                       ingressPeriodSel,
   output logic                             egressQueueMode
);

   logic [1:0]               rstSync_q;
   logic                     rstSyncN;
   logic                     ack_q;
   logic [sfp_pkg::DATA_W-1:0] datR_q;
   logic [7:0]               selfIpmc_q;
   logic [7:0]               rateTag_q;
   logic                     wbReq;
   logic                     wrEn;
   logic [7:0]               idx;
   logic [7:0]               rdByte;
   logic [CNT_W-1:0]         perCnt_q;
   logic                     tick_q;
   sfp_pkg::sfp_res_t        res_q;
   logic                     selfHit;
   logic                     tagSel;

   function automatic logic [7:0] regIdx(input logic [sfp_pkg::ADDR_W-1:0] a);
      regIdx = a[sfp_pkg::ADDR_W-1:2];
   endfunction

   function automatic logic [CNT_W-1:0] perCycles(input logic [1:0] s);
      case (s)
         sfp_pkg::SFP_PER_SHORT: perCycles = CNT_W'(PER_SHORT_CYC);
         sfp_pkg::SFP_PER_MID:   perCycles = CNT_W'(PER_MID_CYC);
         default:                perCycles = CNT_W'(PER_LONG_CYC);
      endcase
   endfunction

   // Only one flop of the pair feeds logic; the first is read by the second
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rstSync_q <= 2'b00;
      end else begin
         rstSync_q <= {rstSync_q[0], 1'b1};
      end
   end
   assign rstSyncN = rstSync_q[1];

   assign wbReq = wbCyc & wbStb & ~ack_q;
   assign wrEn  = wbReq & wbWe & wbSel[0];
   assign idx   = regIdx(wbAdr);

   // One wait state: ack follows the request by one edge and drops after one
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wbReq;
      end
   end
   assign wbAck = ack_q;

   // Writable bits only; reserved bits keep their reset value
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         selfIpmc_q <= sfp_pkg::SELF_IPMC_RST;
      end else if (wrEn && idx == sfp_pkg::IDX_SELF_IPMC) begin
         selfIpmc_q <= (wbDatW[7:0] & sfp_pkg::SELF_IPMC_WM)
                     | (sfp_pkg::SELF_IPMC_RST & ~sfp_pkg::SELF_IPMC_WM);
      end
   end

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         rateTag_q <= sfp_pkg::RATE_TAG_RST;
      end else if (wrEn && idx == sfp_pkg::IDX_RATE_TAG) begin
         rateTag_q <= (wbDatW[7:0] & sfp_pkg::RATE_TAG_WM)
                    | (sfp_pkg::RATE_TAG_RST & ~sfp_pkg::RATE_TAG_WM);
      end
   end

   // Read mux; unmapped addresses still ack and read as zero
   always_comb begin
      case (idx)
         sfp_pkg::IDX_SELF_IPMC: rdByte = selfIpmc_q;
         sfp_pkg::IDX_RATE_TAG:  rdByte = rateTag_q;
         sfp_pkg::IDX_REVISION:  rdByte = {REV_CODE, 4'h0};
         default:                rdByte = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         datR_q <= 32'h00000000;
      end else if (wbReq && !wbWe) begin
         datR_q <= {24'h000000, rdByte};
      end
   end
   assign wbDatR = datR_q;

   // Window restarts early if software shrinks the period mid-count
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         perCnt_q <= '0;
         tick_q   <= 1'b0;
      end else if (perCnt_q >= perCycles(ingressPeriodSel) - CNT_W'(1)) begin
         perCnt_q <= '0;
         tick_q   <= 1'b1;
      end else begin
         perCnt_q <= perCnt_q + CNT_W'(1);
         tick_q   <= 1'b0;
      end
   end
   assign ingressTick      = tick_q;
   assign ingressPeriodSel = rateTag_q[sfp_pkg::RL_PER_LSB +: 2];
   assign egressQueueMode  = rateTag_q[sfp_pkg::EGR_QUEUE_BIT];

   // Per-frame decision, using the live register values
   assign selfHit = selfIpmc_q[sfp_pkg::SELF_FILT_BIT]
                  & (req.dstMac == selfMac);
   assign tagSel  = rateTag_q[sfp_pkg::SRC_TAG_BIT];

   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         res_q <= '0;
      end else begin
         res_q.valid    <= req.valid;
         res_q.selfDrop <= req.valid & selfHit;
         res_q.ipmcMask <= (req.valid & req.unknownIpMc & selfIpmc_q[sfp_pkg::IPMC_EN_BIT])
                         ? selfIpmc_q[sfp_pkg::IPMC_MAP_MSB:sfp_pkg::IPMC_MAP_LSB]
                         : 4'h0;
         if (tagSel) begin
            res_q.insertTag <= req.valid
                             & srcTagMask[{req.egressPort, req.srcPort}];
         end else begin
            res_q.insertTag <= req.valid & portInsertTag[req.egressPort];
         end
      end
   end
   assign res = res_q;

   // Helpers for the window check
   // A plain register for the old field keeps this helper synthesisable
   logic [CNT_W-1:0] gap_q;
   logic             selMoved_q;
   logic [1:0]       prevSel_q;
   always_ff @(posedge clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         gap_q      <= '0;
         selMoved_q <= 1'b0;
         prevSel_q  <= sfp_pkg::RATE_TAG_RST[sfp_pkg::RL_PER_LSB +: 2];
      end else begin
         gap_q      <= tick_q ? CNT_W'(1) : gap_q + CNT_W'(1);
         selMoved_q <= tick_q ? 1'b0 : (selMoved_q | (ingressPeriodSel != prevSel_q));
         prevSel_q  <= ingressPeriodSel;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstSyncN);

   property p_self_drop;
      req.valid && req.dstMac == selfMac && selfIpmc_q[sfp_pkg::SELF_FILT_BIT]
         |=> res.valid && res.selfDrop;
   endproperty
   a_self_drop: assert property (p_self_drop)
      else $error("Own-address frame not dropped");

   property p_no_drop_off;
      !selfIpmc_q[sfp_pkg::SELF_FILT_BIT] |=> !res.selfDrop;
   endproperty
   a_no_drop_off: assert property (p_no_drop_off)
      else $error("Frame dropped with filter off");

   property p_drop_cause;
      res.selfDrop |-> $past(req.dstMac) == $past(selfMac);
   endproperty
   a_drop_cause: assert property (p_drop_cause)
      else $error("Drop without self MAC match");

   property p_ipmc_off;
      !selfIpmc_q[sfp_pkg::IPMC_EN_BIT] |=> res.ipmcMask == 4'h0;
   endproperty
   a_ipmc_off: assert property (p_ipmc_off)
      else $error("Port map used while disabled");

   property p_ipmc_two;
      req.valid && req.unknownIpMc && selfIpmc_q[6:0] == 7'h27
         |=> res.ipmcMask == 4'h3;
   endproperty
   a_ipmc_two: assert property (p_ipmc_two)
      else $error("Map 0011x not to ports 1 and 2");

   property p_ipmc_lsb;
      req.valid && req.unknownIpMc && selfIpmc_q[5:0] == 6'h21 |=> res.ipmcMask == 4'h0;
   endproperty
   a_ipmc_lsb: assert property (p_ipmc_lsb)
      else $error("Map bit zero changed the result");

   property p_window;
      tick_q && !selMoved_q && gap_q > CNT_W'(1) |-> gap_q == perCycles(ingressPeriodSel);
   endproperty
   a_window: assert property (p_window)
      else $error("Ingress window length wrong");

   property p_mode_write;
      wrEn && idx == sfp_pkg::IDX_RATE_TAG |=> egressQueueMode == $past(wbDatW[3]);
   endproperty
   a_mode_write: assert property (p_mode_write)
      else $error("Egress mode not taken from write");

   property p_src_tag;
      req.valid && tagSel |=> res.insertTag == $past(srcTagMask[{req.egressPort, req.srcPort}]);
   endproperty
   a_src_tag: assert property (p_src_tag)
      else $error("Source-port tag option ignored");

   property p_port_tag;
      req.valid && !tagSel |=> res.insertTag == $past(portInsertTag[req.egressPort]);
   endproperty
   a_port_tag: assert property (p_port_tag)
      else $error("Port insert bit ignored");

   property p_rev_read;
      wbReq && !wbWe && idx == sfp_pkg::IDX_REVISION |=> wbAck && wbDatR == {24'h0, REV_CODE, 4'h0};
   endproperty
   a_rev_read: assert property (p_rev_read)
      else $error("Revision read wrong");

   property p_reserved;
      rateTag_q[7:6] == 2'b00 && rateTag_q[1:0] == 2'b00 && !selfIpmc_q[7];
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("Reserved bit changed");

   // Register side: writes land where meant, and only there; ack and ingress tick last one cycle
   property p_self_write;
      wrEn && idx == sfp_pkg::IDX_SELF_IPMC |=> selfIpmc_q[6:0] == $past(wbDatW[6:0]);
   endproperty
   a_self_write: assert property (p_self_write)
      else $error("Filter register write lost");

   property p_sel_ignored;
      wbReq && wbWe && !wbSel[0] |=> $stable(selfIpmc_q) && $stable(rateTag_q);
   endproperty
   a_sel_ignored: assert property (p_sel_ignored)
      else $error("Write without byte enable stored");

   property p_period_write;
      wrEn && idx == sfp_pkg::IDX_RATE_TAG |=> ingressPeriodSel == $past(wbDatW[5:4]);
   endproperty
   a_period_write: assert property (p_period_write)
      else $error("Period field not taken from write");

   property p_mode_hold;
      !(wrEn && idx == sfp_pkg::IDX_RATE_TAG) |=> $stable(egressQueueMode);
   endproperty
   a_mode_hold: assert property (p_mode_hold)
      else $error("Egress mode changed without write");

   property p_ack_once;
      wbAck |=> !wbAck;
   endproperty
   a_ack_once: assert property (p_ack_once)
      else $error("Ack held for two cycles");

   property p_tick_pulse;
      ingressTick |=> !ingressTick;
   endproperty
   a_tick_pulse: assert property (p_tick_pulse)
      else $error("Ingress tick longer than one cycle");

   // Decision side: each field follows its own rule
   property p_self_miss;
      req.valid && req.dstMac != selfMac |=> !res.selfDrop;
   endproperty
   a_self_miss: assert property (p_self_miss)
      else $error("Frame to other address dropped");

   property p_ipmc_known;
      req.valid && !req.unknownIpMc |=> res.ipmcMask == 4'h0;
   endproperty
   a_ipmc_known: assert property (p_ipmc_known)
      else $error("Port map used for known frame");

   property p_ipmc_one;
      req.valid && req.unknownIpMc && selfIpmc_q[5:1] == 5'h11 |=> res.ipmcMask == 4'h1;
   endproperty
   a_ipmc_one: assert property (p_ipmc_one)
      else $error("Map 0001x not to port 1");

   property p_ipmc_port2;
      req.valid && req.unknownIpMc && selfIpmc_q[5:1] == 5'h12 |=> res.ipmcMask == 4'h2;
   endproperty
   a_ipmc_port2: assert property (p_ipmc_port2)
      else $error("Map 0010x not to port 2");

   property p_ipmc_all;
      req.valid && req.unknownIpMc && selfIpmc_q[5:1] == 5'h1F |=> res.ipmcMask == 4'hF;
   endproperty
   a_ipmc_all: assert property (p_ipmc_all)
      else $error("Map 1111x not to all ports");

   property p_idle;
      !req.valid
         |=> !res.valid && !res.selfDrop && res.ipmcMask == 4'h0 && !res.insertTag;
   endproperty
   a_idle: assert property (p_idle)
      else $error("Result shown without request");

   c_self_drop: cover property (res.selfDrop);
   c_ipmc_all:  cover property (res.ipmcMask == 4'hF);
   c_tick:      cover property (ingressTick);
   c_rev:       cover property (wbAck && wbDatR[7:4] == REV_CODE);
   c_src_tag:   cover property (res.valid && res.insertTag && tagSel);
endmodule

// [test/test_sfp_policy_regs.sv]
// Self-checking bench for the forwarding policy register bank.
// Drives Wishbone, switch context and decision requests directly; short windows.
module test_sfp_policy_regs;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [3:0]  REV = 4'hC; // Arbitrary revision value
   localparam int unsigned PS  = 8;
   localparam int unsigned PM  = 16;
   localparam int unsigned PL  = 32;
   localparam logic [47:0] MAC = 48'h0A1B2C3D4E5F;

   logic                clk           = 1'b0;
   logic                rstn          = 1'b0;
   logic                wbCyc         = 1'b0;
   logic                wbStb         = 1'b0;
   logic                wbWe          = 1'b0;
   logic [9:0]          wbAdr         = 10'h000;
   logic [3:0]          wbSel         = 4'h0;
   logic [31:0]         wbDatW        = 32'h00000000;
   logic [31:0]         wbDatR;
   logic                wbAck;
   logic [47:0]         selfMac       = MAC;
   logic [3:0]          portInsertTag = 4'h0;
   logic [15:0]         srcTagMask    = 16'h0000;
   sfp_pkg::sfp_req_t   req           = '0;
   sfp_pkg::sfp_res_t   res;
   logic                ingressTick;
   logic [1:0]          ingressPeriodSel;
   logic                egressQueueMode;
   int                  badCount      = 0;
   int                  checksDone    = 0;

   always #12.5 clk = ~clk;

   sfp_policy_regs #(.PER_SHORT_CYC(PS), .PER_MID_CYC(PM), .PER_LONG_CYC(PL),
                     .REV_CODE(REV)) dut_u (
      .clk(clk), .rstn(rstn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
      .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck), .selfMac(selfMac),
      .portInsertTag(portInsertTag), .srcTagMask(srcTagMask), .req(req), .res(res),
      .ingressTick(ingressTick), .ingressPeriodSel(ingressPeriodSel),
      .egressQueueMode(egressQueueMode));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checksDone++;
      if (got !== exp) begin
         badCount++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic giveVerdict();
      if (badCount == 0 && checksDone > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Holds the request until ack is sampled, then releases for one cycle at least
   task automatic wbRw(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                       input logic [3:0] sel, output logic [31:0] got);
      int n;
      n = 0;
      @(posedge clk);
      wbCyc  <= 1'b1;
      wbStb  <= 1'b1;
      wbWe   <= we;
      wbAdr  <= {idx, 2'b00};
      wbSel  <= sel;
      wbDatW <= {24'hFFFFFF, wd};
      do begin
         @(posedge clk);
         n++;
      end while (wbAck !== 1'b1);
      got = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      chk("wb ack latency", 32'h2, 32'(n));
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] wd, input logic [3:0] sel = 4'h1);
      logic [31:0] d;
      wbRw(1'b1, idx, wd, sel, d);
   endtask

   task automatic rdChk(input string what, input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      wbRw(1'b0, idx, 8'h00, 4'hF, d);
      chk(what, exp, d);
   endtask

   // Result is registered on the same edge that samples the request
   task automatic decide(input logic [47:0] mac, input int i, input logic unk);
      @(posedge clk);
      req <= '{valid: 1'b1, egressPort: 2'(i / 4), srcPort: 2'(i % 4), dstMac: mac,
               unknownIpMc: unk};
      @(posedge clk);
      #1;
   endtask

   task automatic testRegs();
      rdChk("ctl86 reset", 8'h86, 32'h00000000);
      rdChk("ctl88 reset", 8'h88, 32'h00000010);
      chk("periodSel reset", 32'h1, 32'(ingressPeriodSel));
      chk("queueMode reset", 32'h0, 32'(egressQueueMode));
      rdChk("revision", 8'h89, {24'h0, REV, 4'h0});
      wr(8'h86, 8'hFF);
      rdChk("ctl86 reserved", 8'h86, 32'h0000007F);
      wr(8'h86, 8'h00, 4'hE);
      rdChk("ctl86 sel off", 8'h86, 32'h0000007F);
      wr(8'h88, 8'hFF);
      rdChk("ctl88 reserved", 8'h88, 32'h0000003C);
      wr(8'h89, 8'h55);
      rdChk("revision ro", 8'h89, {24'h0, REV, 4'h0});
      wr(8'h87, 8'hFF);
      rdChk("unmapped", 8'h87, 32'h00000000);
      wr(8'h88, 8'h10);
   endtask

   task automatic testSelf();
      wr(8'h86, 8'h40);
      decide(MAC, 13, 1'b0);
      chk("selfDrop own", 32'h1, 32'(res.selfDrop));
      chk("res valid", 32'h1, 32'(res.valid));
      decide(MAC ^ 48'h800000000000, 13, 1'b0);
      chk("selfDrop other", 32'h0, 32'(res.selfDrop));
      @(posedge clk);
      selfMac <= MAC ^ 48'h000000000001;
      decide(MAC ^ 48'h000000000001, 5, 1'b0);
      chk("selfDrop new self", 32'h1, 32'(res.selfDrop));
      decide(MAC, 5, 1'b0);
      chk("selfDrop old self", 32'h0, 32'(res.selfDrop));
      wr(8'h86, 8'h00);
      decide(MAC, 2, 1'b0);
      chk("selfDrop off", 32'h0, 32'(res.selfDrop));
   endtask

   task automatic testIpmc();
      for (int m = 0; m < 32; m++) begin
         wr(8'h86, {3'b001, 5'(m)});
         decide(48'h01005E000001, m % 16, 1'b1);
         chk("ipmcMask", 32'(m[4:1]), 32'(res.ipmcMask));
      end
      decide(48'h01005E000001, 0, 1'b0);
      chk("ipmcMask known", 32'h0, 32'(res.ipmcMask));
      wr(8'h86, 8'h1F);
      decide(48'h01005E000001, 0, 1'b1);
      chk("ipmcMask off", 32'h0, 32'(res.ipmcMask));
   endtask

   task automatic testTag();
      @(posedge clk);
      srcTagMask    <= 16'hA5C3;
      portInsertTag <= 4'b0110;
      for (int s = 0; s < 2; s++) begin
         wr(8'h88, s ? 8'h14 : 8'h10);
         for (int i = 0; i < 16; i++) begin
            decide(48'h020000000001, i, 1'b0);
            chk("insertTag", 32'(s ? srcTagMask[i] : portInsertTag[i / 4]),
                32'(res.insertTag));
         end
      end
   endtask

   // The gap between two ticks is timed under each setting; the first may end a cut-short window
   task automatic testTick();
      int n;
      for (int k = 0; k < 4; k++) begin
         wr(8'h88, {2'b00, 2'(k), k[0], 3'b000});
         chk("periodSel", 32'(k), 32'(ingressPeriodSel));
         chk("queueMode", 32'(k[0]), 32'(egressQueueMode));
         n = 0;
         while (ingressTick !== 1'b1 && n < 100) begin
            @(posedge clk);
            n++;
         end
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (ingressTick !== 1'b1 && n < 100);
         chk("tick period", k == 0 ? PS : (k == 1 ? PM : PL), 32'(n));
      end
   endtask

   initial begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      testRegs();
      testSelf();
      testIpmc();
      testTag();
      testTick();
      giveVerdict();
   end

   // The full run needs about 500 cycles; this leaves a wide margin
   initial begin
      #100us;
      badCount++;
      giveVerdict();
   end
endmodule
